// >>> design/dao_map.svh
`ifndef DAO_MAP_SVH
`define DAO_MAP_SVH

// register offsets (byte addresses)
`define DAO_REG_CFG 8'h00
`define DAO_REG_STATUS 8'h04

// configuration word fields
`define DAO_CFG_SDLY_LSB 0
`define DAO_CFG_DIR0_LSB 2
`define DAO_CFG_DIR1_LSB 4
`define DAO_CFG_Q115_LSB 6
`define DAO_CFG_GRP_LSB 8
`define DAO_CFG_SUM_BIT 16
`define DAO_CFG_RESET 32'h0000_E400
`define DAO_CFG_MASK 32'h0001_FFFF

// status word fields
`define DAO_ST_MODE_LSB 0
`define DAO_ST_M36_BIT 4
`define DAO_ST_CLAMP_LSB 5
`define DAO_ST_OVF_LSB 7

// arithmetic constants
`define DAO_ACC_W 52
`define DAO_RND_ADD 52'h0_0000_0004_0000
`define DAO_RND_MASK 52'h0_0000_0007_FFFF
`define DAO_SAT_POS 52'h0_0003_FFFF_FFF8
`define DAO_SAT_NEG 52'hF_FFFC_0000_0000

`endif

// >>> design/dao_pkg.sv
package dao_pkg;

    typedef enum logic [1:0] {
        MODE_MULT,
        MODE_MAC,
        MODE_ADD2
    } dao_mode_t;

    typedef enum logic [1:0] {
        DIR_DYN,
        DIR_ADD,
        DIR_SUB
    } dao_dir_t;

    typedef enum logic [1:0] {
        SDLY_NONE,
        SDLY_ONE,
        SDLY_TWO
    } dao_sdly_t;

endpackage : dao_pkg

// >>> design/dao_adder_output_stage.sv
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dao_map.svh"
// Overview of operation
// RQ1: accumulator mode feeds registered total back into the adder.
// RQ2: accumulator adds, subtracts, or follows direction pin; high adds.
// RQ3: clear by output register clear or by sync-load, no lost cycle.
// RQ4: sync-load with zero preload gives the product alone.
// RQ5: sync-load selects preload bus as feedback, product added to it.
// RQ6: preload sets upper 36 bits; low bits come through multiply-by-one.
// RQ7: accumulator is 52 bits; preload covers bits 51 to 16.
// RQ8: overflow flag pulses one cycle even if condition persists.
// RQ9: fabric latches the overflow pulse if it must be kept.
// RQ10: two independent round/saturate enable pairs, one per accumulator.
// RQ11: accumulator round/saturate only with Q1.15 operands.
// RQ12: clamp flag high whenever saturation was applied.
// RQ13: round adds 0x00008000 (1.31); saturate clamps to 0x7FFFFFFF.
// RQ14: each adder has own direction pin; low gives A-B or C-D.
// RQ15: adders use multiplier sign controls, delayed zero, one or two.
// RQ16: optional Q1.15 rounding per adder, no saturation.
// RQ17: adder rounding only with Q1.15 operands.
// RQ18: summation adder adds both first-level adder outputs.
// RQ19: output mux picks products, adder/accumulator or summation.
// RQ20: each output register uses one of four enable/clear groups.
// RQ21: in accumulate mode the output register is the accumulator.
// RQ22: simple mode gives separate products or one 36x36 product.
// RQ23: two 52-bit accumulators; two- and four-product adders.
// RQ24: co-resident modes share the same operand sign settings.
// RQ25: per-half dynamic mode, 36-bit multiply switches whole block.
// RQ26: output register clear zeroes value, accumulator and flags.

module dao_adder_output_stage (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0][35:0] prod,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic top_adder_direction,
    input wire logic bottom_adder_direction,
    input wire logic top_adder_round_enable,
    input wire logic bottom_adder_round_enable,
    input wire logic [1:0] accum_direction,
    input wire logic [1:0] accum_sload,
    input wire logic [1:0][35:0] accum_preload_upper,
    input wire logic [1:0] accum_round_enable,
    input wire logic [1:0] accum_saturate_enable,
    input wire logic [1:0][1:0] half_mode,
    input wire logic whole_block_m36,
    input wire logic [3:0] out_ena,
    input wire logic [3:0] out_clear,
    output logic [3:0][51:0] result,
    output logic [1:0] accum_overflow,
    output logic [1:0] accum_clamp_flag
);

    logic [31:0] cfg_q;
    logic [31:0] rdata_q;
    logic [1:0] sd1_q;
    logic [1:0] sd2_q;
    logic [3:0][51:0] out_q;
    logic [1:0][51:0] acc_q;
    logic [1:0] ovf_q;
    logic [1:0] prev_q;
    logic [1:0] clamp_q;

    // sign-extend a product when either operand is signed
    function automatic logic [51:0] ext(input logic [35:0] p,
                                        input logic sg);
        ext = {{16{sg & p[35]}}, p};
    endfunction : ext

    // add half an output lsb, then drop the bits below it
    function automatic logic [51:0] rnd(input logic [51:0] x);
        rnd = (x + `DAO_RND_ADD) & ~`DAO_RND_MASK;
    endfunction : rnd

    // ---------------- register port ----------------
    wire logic sel_cfg = reg_addr == `DAO_REG_CFG;
    wire logic sel_st = reg_addr == `DAO_REG_STATUS;
    wire logic [1:0] sdly = cfg_q[`DAO_CFG_SDLY_LSB +: 2];
    wire logic [1:0] q115 = cfg_q[`DAO_CFG_Q115_LSB +: 2];
    wire logic sum_en = cfg_q[`DAO_CFG_SUM_BIT];
    wire logic [31:0] st_word;
    wire logic [31:0] rd_mux;

    assign st_word = {23'h0, prev_q, clamp_q, whole_block_m36,
                      half_mode[1], half_mode[0]};
    assign rd_mux = sel_cfg ? cfg_q : (sel_st ? st_word : 32'h0);
    assign reg_rdata = rdata_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= `DAO_CFG_RESET;
            rdata_q <= 32'h0;
        end else if (clk_en) begin
            if (reg_wr && sel_cfg) begin
                cfg_q <= reg_wdata & `DAO_CFG_MASK;
            end
            rdata_q <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ---------------- sign controls ----------------
    wire logic [1:0] sgn_now = {sign_b, sign_a};
    wire logic [1:0] sgn;
    wire logic sg;

    // RQ15 sign pipeline select
    assign sgn = (sdly == dao_pkg::SDLY_NONE) ? sgn_now :
                 (sdly == dao_pkg::SDLY_ONE) ? sd1_q : sd2_q;
    // RQ24 one shared sign setting
    assign sg = |sgn;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sd1_q <= 2'h0;
            sd2_q <= 2'h0;
        end else if (clk_en) begin
            sd1_q <= sgn_now;
            sd2_q <= sd1_q;
        end
    end

    // ---------------- enable / clear groups ----------------
    logic [3:0] ld;
    logic [3:0] clr;

    for (genvar i = 0; i < 4; i++) begin : g_grp
        wire logic [1:0] grp = cfg_q[`DAO_CFG_GRP_LSB + 2 * i +: 2];
        // RQ20 group select per output register
        assign ld[i] = clk_en & out_ena[grp];
        assign clr[i] = out_clear[grp];
    end

    // ---------------- per half datapath ----------------
    wire logic [1:0] as_dir = {bottom_adder_direction,
                               top_adder_direction};
    wire logic [1:0] as_rnd = {bottom_adder_round_enable,
                               top_adder_round_enable};
    logic [1:0][51:0] as_res;
    logic [1:0][51:0] mac_res;
    logic [1:0][51:0] acc_d;
    logic [1:0] mac_sat;
    logic [1:0] mac_cond;
    logic [1:0] is_mac;
    dao_pkg::dao_mode_t [1:0] hm;

    for (genvar h = 0; h < 2; h++) begin : g_half
        wire logic [51:0] pa = ext(prod[2 * h], sg);
        wire logic [51:0] pb = ext(prod[2 * h + 1], sg);
        wire logic [51:0] as_raw;
        wire logic [1:0] dmode = cfg_q[`DAO_CFG_DIR0_LSB + 2 * h +: 2];
        wire logic acc_add;
        wire logic [51:0] fb;
        wire logic [52:0] fx;
        wire logic [52:0] px;
        wire logic [52:0] s53;
        wire logic [51:0] r;
        wire logic sat_need;

        assign hm[h] = dao_pkg::dao_mode_t'(half_mode[h]);
        // RQ25 per-half mode, overridden by whole-block modes
        assign is_mac[h] = (hm[h] == dao_pkg::MODE_MAC) &
                           ~whole_block_m36 & ~sum_en;

        // RQ14 high adds, low gives A-B / C-D
        assign as_raw = as_dir[h] ? pa + pb : pa - pb;
        // RQ16 RQ17 optional Q1.15 rounding, no saturation
        assign as_res[h] = (as_rnd[h] & q115[h]) ? rnd(as_raw) : as_raw;

        // RQ2 fixed or dynamic direction
        assign acc_add = (dmode == dao_pkg::DIR_ADD) ? 1'b1 :
                         (dmode == dao_pkg::DIR_SUB) ? 1'b0 :
                         accum_direction[h];
        // RQ3 RQ4 RQ5 RQ6 RQ7 feedback mux: preload or total
        assign fb = accum_sload[h] ? {accum_preload_upper[h], 16'h0}
                                   : acc_q[h];
        assign fx = {sg & fb[51], fb};
        assign px = {sg & pa[51], pa};
        // RQ1 product combined with the running total
        assign s53 = acc_add ? fx + px : fx - px;
        assign acc_d[h] = s53[51:0];
        // RQ8 signed overflow, or carry/borrow when unsigned
        assign mac_cond[h] = sg ? (s53[52] ^ s53[51]) : s53[52];

        // RQ10 RQ11 RQ13 rounding before saturation
        assign r = (accum_round_enable[h] & q115[h]) ? rnd(acc_d[h])
                                                     : acc_d[h];
        assign sat_need = accum_saturate_enable[h] & q115[h] &
                          ~((&r[51:34]) | ~(|r[51:34]));
        // RQ13 clamp to the 1.31 limits
        assign mac_res[h] = sat_need ?
                            (r[51] ? `DAO_SAT_NEG : `DAO_SAT_POS) : r;
        assign mac_sat[h] = sat_need;
    end

    // ---------------- summation and 36x36 ----------------
    wire logic [51:0] sum_r;
    wire logic [71:0] m36_r;
    wire logic [71:0] pp_hh = {{36{sg & prod[0][35]}}, prod[0]};
    wire logic [71:0] pp_hl = {{36{sg & prod[1][35]}}, prod[1]};
    wire logic [71:0] pp_lh = {{36{sg & prod[2][35]}}, prod[2]};
    wire logic [71:0] pp_ll = {36'h0, prod[3]};

    // RQ18 second-level adder
    assign sum_r = as_res[0] + as_res[1];
    // RQ22 partial products of one 36x36 multiply
    assign m36_r = (pp_hh << 36) + (pp_hl << 18) + (pp_lh << 18) + pp_ll;

    // ---------------- output select ----------------
    logic [3:0][51:0] nxt;

    for (genvar i = 0; i < 4; i++) begin : g_sel
        localparam int H = i / 2;
        localparam bit EVEN = (i % 2) == 0;
        wire logic [51:0] m36_w;
        wire logic [51:0] sum_w;
        wire logic [51:0] half_w;

        assign m36_w = (i == 0) ? m36_r[51:0] :
                       (i == 1) ? {32'h0, m36_r[71:52]} : 52'h0;
        assign sum_w = (i == 0) ? sum_r : 52'h0;
        // RQ19 RQ23 half result: accumulator, adder or product
        assign half_w = is_mac[H] ? (EVEN ? mac_res[H] : 52'h0) :
                        (hm[H] == dao_pkg::MODE_ADD2) ?
                        (EVEN ? as_res[H] : 52'h0) : ext(prod[i], sg);
        // RQ19 RQ25 whole-block modes win over half modes
        assign nxt[i] = whole_block_m36 ? m36_w :
                        sum_en ? sum_w : half_w;

        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                out_q[i] <= 52'h0;
            end else if (clr[i]) begin
                out_q[i] <= 52'h0;
            end else if (ld[i]) begin
                out_q[i] <= nxt[i];
            end
        end

        // RQ26 clear shows zero at once
        assign result[i] = clr[i] ? 52'h0 : out_q[i];
    end

    // ---------------- accumulator storage and flags ----------------
    for (genvar h = 0; h < 2; h++) begin : g_acc
        wire logic upd = ld[2 * h] & is_mac[h];

        // RQ21 RQ26 total lives with the half's output register
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                acc_q[h] <= 52'h0;
                prev_q[h] <= 1'b0;
                clamp_q[h] <= 1'b0;
            end else if (clr[2 * h]) begin
                acc_q[h] <= 52'h0;
                prev_q[h] <= 1'b0;
                clamp_q[h] <= 1'b0;
            end else if (upd) begin
                acc_q[h] <= acc_d[h];
                prev_q[h] <= mac_cond[h];
                // RQ12 clamp flag
                clamp_q[h] <= mac_sat[h];
            end
        end

        // RQ8 one-cycle pulse on a new overflow
        always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
                ovf_q[h] <= 1'b0;
            end else if (clr[2 * h]) begin
                ovf_q[h] <= 1'b0;
            end else if (clk_en) begin
                ovf_q[h] <= upd & mac_cond[h] & ~prev_q[h];
            end
        end

        assign accum_overflow[h] = clr[2 * h] ? 1'b0 : ovf_q[h];
        assign accum_clamp_flag[h] = clr[2 * h] ? 1'b0 : clamp_q[h];
    end

endmodule : dao_adder_output_stage
`default_nettype wire

// >>> bench/dao_fabric_latch.sv
`timescale 1ns/1ps
`default_nettype none
module dao_fabric_latch (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [1:0] pulse,
    input wire logic clr,
    output logic [1:0] held_q
);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            held_q <= 2'b00;
        end else if (clr) begin
            held_q <= 2'b00;
        end else begin
            held_q <= held_q | pulse;
        end
    end
endmodule : dao_fabric_latch
`default_nettype wire

// >>> bench/dao_adder_output_stage_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dao_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0][35:0] prod,
    input wire logic sign_a,
    input wire logic sign_b,
    input wire logic whole_block_m36,
    input wire logic bottom_adder_direction,
    input wire logic bottom_adder_round_enable,
    input wire logic [1:0] accum_direction,
    input wire logic [1:0] accum_sload,
    input wire logic [1:0][35:0] accum_preload_upper,
    input wire logic [1:0] accum_round_enable,
    input wire logic [1:0] accum_saturate_enable,
    input wire logic [1:0][1:0] half_mode,
    input wire logic [3:0] out_ena,
    input wire logic [3:0] out_clear,
    input wire logic [3:0][51:0] result,
    input wire logic [1:0] accum_overflow,
    input wire logic [1:0] accum_clamp_flag
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    // unsigned load, default config
    wire logic us = clk_en && out_clear == 4'h0 && !whole_block_m36
        && !sign_a && !sign_b;
    wire logic mac = us && half_mode[0] == 2'h1 && out_ena[0]
        && !accum_round_enable[0] && !accum_saturate_enable[0];
    wire logic [51:0] pre = {accum_preload_upper[0], 16'h0};
    wire logic [51:0] p0 = 52'(prod[0]);
    wire logic [51:0] p1 = 52'(prod[1]);
    wire logic [51:0] p2 = 52'(prod[2]);
    wire logic [51:0] p3 = 52'(prod[3]);
    a_sload_fresh: assert property (
        mac && accum_sload[0] ##1 out_clear == 4'h0 |-> result[0] ==
        ($past(accum_direction[0]) ? $past(pre) + $past(p0)
        : $past(pre) - $past(p0)))
        else $error("sload total wrong");
    a_accum_feedback: assert property (
        mac ##1 mac && !accum_sload[0] ##1 out_clear == 4'h0 |->
        result[0] == ($past(accum_direction[0])
        ? $past(result[0]) + $past(p0) : $past(result[0]) - $past(p0)))
        else $error("accumulate total wrong");
    a_add2_bottom: assert property (
        us && half_mode[1] == 2'h2 && out_ena[2] && !bottom_adder_round_enable
        ##1 out_clear == 4'h0 |-> result[2] == ($past(bottom_adder_direction)
        ? $past(p2) + $past(p3) : $past(p2) - $past(p3)))
        else $error("bottom adder wrong");
    a_mult_pass: assert property (
        us && half_mode[0] == 2'h0 && out_ena[1] ##1 out_clear == 4'h0
        |-> result[1] == $past(p1))
        else $error("product output wrong");
    a_ovf_single: assert property (
        $past(clk_en) |-> (accum_overflow & $past(accum_overflow)) == 2'b00)
        else $error("overflow longer than one cycle");
    a_clear_out: assert property (
        out_clear == 4'hF |-> result == '0 && accum_overflow == 2'b00)
        else $error("clear did not zero outputs");
    a_clamp_clear: assert property (
        out_clear == 4'hF |=> accum_clamp_flag == 2'b00)
        else $error("clear left clamp flag");
    a_freeze_hold: assert property (
        !clk_en && out_clear == 4'h0 ##1 out_clear == 4'h0 |-> $stable(result))
        else $error("result moved while frozen");
    a_rdata_idle: assert property (
        $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    c_sload: cover property (mac && accum_sload[0]);
    c_ovf: cover property (accum_overflow[0]);
    c_clamp: cover property (accum_clamp_flag[0]);
endmodule : dao_chk
bind dao_adder_output_stage dao_chk u_chk (
    .ref_clk, .nrst, .clk_en, .reg_rd, .reg_rdata, .prod, .sign_a,
    .sign_b, .whole_block_m36, .bottom_adder_direction,
    .bottom_adder_round_enable, .accum_direction, .accum_sload,
    .accum_preload_upper, .accum_round_enable, .accum_saturate_enable,
    .half_mode, .out_ena, .out_clear, .result, .accum_overflow,
    .accum_clamp_flag
);
`default_nettype wire

// >>> bench/dao_adder_output_stage_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dao_map.svh"
module dao_adder_output_stage_tb_top;
    logic ref_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1;
    logic reg_wr = 1'b0, reg_rd = 1'b0, sign_a = 1'b0, sign_b = 1'b0;
    logic top_adder_direction = 1'b1, bottom_adder_direction = 1'b1;
    logic top_adder_round_enable = 1'b0, bottom_adder_round_enable = 1'b0;
    logic whole_block_m36 = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [3:0][35:0] prod = '0;
    logic [1:0][35:0] accum_preload_upper = '0;
    logic [1:0] accum_direction = 2'b11, accum_sload = 2'b00;
    logic [1:0] accum_round_enable = 2'b00, accum_saturate_enable = 2'b00;
    logic [1:0][1:0] half_mode = '0;
    logic [3:0] out_ena = 4'h0, out_clear = 4'h0;
    logic [3:0][51:0] result;
    logic [1:0] accum_overflow, accum_clamp_flag, held_q;
    int failures = 0;
    int n_checks = 0;
    dao_adder_output_stage dut (
        .ref_clk, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .prod, .sign_a, .sign_b, .top_adder_direction,
        .bottom_adder_direction, .top_adder_round_enable,
        .bottom_adder_round_enable, .accum_direction, .accum_sload,
        .accum_preload_upper, .accum_round_enable, .accum_saturate_enable,
        .half_mode, .whole_block_m36, .out_ena, .out_clear, .result,
        .accum_overflow, .accum_clamp_flag
    );
    dao_fabric_latch u_latch (
        .ref_clk, .nrst, .pulse(accum_overflow), .clr(out_clear[0]), .held_q
    );
    always #2.5 ref_clk = ~ref_clk;
    task automatic chk(input string nm, input logic [51:0] exp,
        input logic [51:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        tick();
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick();
        reg_rd <= 1'b0;
        chk("reg_rdata", 52'(e), 52'(reg_rdata));
    endtask : rd
    task automatic mac(input logic sl, dr, bd, input logic [35:0] pr, p,
        input logic [51:0] e0, e2);
        accum_sload[0] <= sl;
        accum_direction[0] <= dr;
        bottom_adder_direction <= bd;
        accum_preload_upper[0] <= pr;
        prod[0] <= p;
        tick();
        chk("result0", e0, result[0]);
        chk("result2", e2, result[2]);
    endtask : mac
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        #20000;
        failures++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        tick();
        chk("result0", 52'h0, result[0]);
        rd(`DAO_REG_CFG, `DAO_CFG_RESET);
        rd(8'h08, 32'h0);
        wr(`DAO_REG_CFG, 32'hFFFE_E440);
        rd(`DAO_REG_CFG, 32'h0000_E440);
        half_mode <= 4'h9;
        rd(`DAO_REG_STATUS, 32'h0000_0009);
        out_ena <= 4'hF;
        prod[2] <= 36'hA;
        prod[3] <= 36'h3;
        mac(1'b1, 1'b1, 1'b0, 36'h0, 36'h5, 52'h5, 52'h7);
        mac(1'b0, 1'b1, 1'b1, 36'h0, 36'h3, 52'h8, 52'hD);
        mac(1'b0, 1'b0, 1'b0, 36'h0, 36'h2, 52'h6, 52'h7);
        mac(1'b1, 1'b1, 1'b1, 36'h1, 36'h4, 52'h1_0004, 52'hD);
        mac(1'b1, 1'b1, 1'b1, 36'hF_FFFF_FFFF, 36'h1_0000, 52'h0,
            52'hD);
        chk("overflow", 52'h1, 52'(accum_overflow[0]));
        mac(1'b0, 1'b1, 1'b1, 36'h0, 36'h0, 52'h0, 52'hD);
        chk("overflow", 52'h0, 52'(accum_overflow[0]));
        chk("latch", 52'h1, 52'(held_q[0]));
        accum_round_enable[0] <= 1'b1;
        mac(1'b1, 1'b1, 1'b1, 36'h0, 36'h4_0000, 52'h8_0000,
            52'hD);
        accum_saturate_enable[0] <= 1'b1;
        mac(1'b1, 1'b1, 1'b1, 36'h1_0000_0000, 36'h0, `DAO_SAT_POS,
            52'hD);
        chk("clamp", 52'h1, 52'(accum_clamp_flag[0]));
        accum_round_enable[0] <= 1'b0;
        accum_saturate_enable[0] <= 1'b0;
        clk_en <= 1'b0;
        prod[0] <= 36'h7;
        tick();
        chk("frozen", `DAO_SAT_POS, result[0]);
        clk_en <= 1'b1;
        half_mode <= 4'h8;
        prod[0] <= 36'h123;
        prod[1] <= 36'h456;
        tick();
        chk("result0", 52'h123, result[0]);
        chk("result1", 52'h456, result[1]);
        out_clear <= 4'hF;
        #1;
        chk("result1", 52'h0, result[1]);
        tick();
        chk("clamp", 52'h0, 52'(accum_clamp_flag[0]));
        chk("latch", 52'h0, 52'(held_q[0]));
        // four-product sum, then one 36x36 product
        out_clear <= 4'h0;
        out_ena <= 4'h9;
        wr(`DAO_REG_CFG, 32'h0001_E440);
        tick();
        chk("sum", 52'h586, result[0]);
        chk("result3", 52'h0, result[3]);
        out_ena <= 4'h3;
        whole_block_m36 <= 1'b1;
        tick();
        chk("m36_low", 52'h0_1230_1180_0003, result[0]);
        chk("m36_high", 52'h0, result[1]);
        test_done();
    end
endmodule : dao_adder_output_stage_tb_top
`default_nettype wire
